// file: inc/gpsa_pkg.sv
// statistics and threshold-alarm constants, counter map and event carriers
// assumes the framing datapath and management logic share the same clock
//
// Overview of operation
// RULE_01 - count every received octet since clear
// RULE_02 - count received frames shorter than five bytes
// RULE_03 - count received frames longer than MTU
// RULE_04 - count bad-CRC received frames in HDLC
// RULE_05 - count bad-CRC transmitted frames in HDLC
// RULE_06 - separate transmit oversize and short counters
// RULE_07 - count outbound units dropped by error
// RULE_08 - count GFP frames and octets both ways
// RULE_09 - count received superblock CRC failures
// RULE_10 - count frames with corrected header bit
// RULE_11 - count frames with uncorrectable header errors
// RULE_12 - discard and count wrong payload type
// RULE_13 - count uncorrectable headers only in frame
// RULE_14 - threshold uses period delta or total
// RULE_15 - event only from below falling to above rising
// RULE_16 - rearm once value drops below falling
// RULE_17 - one event per crossing until rearmed
// RULE_18 - counters clear on reset or command
package gpsa_pkg;
    // ------------------------------------------------------------
    // counter map
    // ------------------------------------------------------------
    localparam int CW = 32;             // counter width
    localparam int NCNT = 23;           // number of counters
    localparam int C_RX_OCT = 0, C_RX_FRM = 1, C_RX_ERR = 2, C_TX_OCT = 3;
    localparam int C_TX_FRM = 4, C_TX_ERR = 5, C_RX_SHORT = 6, C_RX_OVER = 7;
    localparam int C_RX_CRC = 8, C_TX_CRC = 9, C_TX_SHORT = 10, C_TX_OVER = 11;
    localparam int C_GFP_RX_FRM = 12, C_GFP_TX_FRM = 13, C_SBLK_CRC = 14;
    localparam int C_GFP_RX_OCT = 15, C_GFP_TX_OCT = 16, C_HDR_CORR = 17;
    localparam int C_HDR_UNCORR = 18, C_BAD_TYPE = 19, C_LOF = 20;
    localparam int C_RX_MGMT = 21, C_TX_MGMT = 22;
    // ------------------------------------------------------------
    // framing limits and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] MIN_FRAME_LEN = 16'h0005;  // shorter is truncated
    localparam logic [CW-1:0] CNT_RST = 32'h0000_0000;
    localparam logic [CW-1:0] PERIOD_RST = 32'h0000_0000;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic [NCNT-1:0][CW-1:0] gpsa_cnt_arr_t;
    typedef struct packed {
        logic        valid;     // one-cycle frame-end strobe
        logic [15:0] length;    // frame length in bytes
        logic        crc_err;   // payload CRC failed
        logic        mgmt;      // client management frame
        logic [3:0]  ptype;     // GFP payload type
    } gpsa_rx_frame_t;
    typedef struct packed {
        logic        valid;
        logic [15:0] length;
        logic        crc_err;
        logic        mgmt;
    } gpsa_tx_frame_t;
    typedef enum logic [0:0] {
        GPSA_OUT_FRAME = 1'b0,
        GPSA_IN_FRAME  = 1'b1
    } gpsa_delin_t;
endpackage

// file: logic/gpsa_stats.sv
// port statistics counters, GFP delineation tracking and one RMON-style alarm
// assumes all event inputs are same-clock pulses from the framing datapath
`timescale 1ns/100ps
module gpsa_stats
    import gpsa_pkg::*;
(
    // clock and reset
    input  wire logic           i_clock,
    input  wire logic           i_resetn,
    // configuration
    input  wire logic           i_hdlc_mode,      // 1 hdlc, 0 gfp
    input  wire logic [15:0]    i_mtu,            // max frame length
    input  wire logic [3:0]     i_expect_type,    // expected client type
    input  wire logic           i_clear_stats,    // one-cycle clear command
    // receive events
    input  wire logic [7:0]     i_rx_octets,      // bytes received this cycle
    input  wire gpsa_rx_frame_t i_rx_frame,
    input  wire logic           i_sblk_crc_err,   // superblock crc fail pulse
    input  wire logic           i_hdr_corrected,  // single-bit header fix pulse
    input  wire logic           i_hdr_uncorr,     // multi-bit header error pulse
    input  wire logic           i_gfp_sync,       // delineation regained pulse
    // transmit events
    input  wire logic [7:0]     i_tx_octets,
    input  wire gpsa_tx_frame_t i_tx_frame,
    input  wire logic           i_tx_drop,        // unit not sent, error
    // alarm configuration
    input  wire logic [4:0]     i_alarm_sel,      // counter under watch
    input  wire logic           i_alarm_absolute, // 1 total, 0 per period
    input  wire logic [CW-1:0]  i_sample_period,  // cycles per sample
    input  wire logic [CW-1:0]  i_rise_thresh,
    input  wire logic [CW-1:0]  i_fall_thresh,
    // status outputs
    output logic                o_rx_discard,     // frame discarded, bad type
    output logic                o_in_frame,       // delineation state
    output gpsa_cnt_arr_t       o_counts,
    output logic [CW-1:0]       o_alarm_value,    // last sampled value
    output logic                o_alarm_armed,
    output logic                o_alarm_event     // one-cycle pulse
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    gpsa_cnt_arr_t          cnt_reg, cnt_next;     // counter bank
    logic [NCNT-1:0][7:0]   inc;                   // per-counter increment
    gpsa_delin_t            delin_reg, delin_next; // delineation state
    logic                   discard_reg, discard_next;
    logic                   gfp;                   // gfp framing selected
    logic                   rx_short, rx_over, tx_short, tx_over;
    logic                   bad_type, rx_crc, uncorr_if;
    logic [CW-1:0]          per_reg, per_next;     // sample period counter
    logic [CW-1:0]          base_reg, base_next;   // count at period start
    logic [CW-1:0]          val_reg, val_next;
    logic                   armed_reg, armed_next;
    logic                   event_reg, event_next;
    logic                   sample_now;
    logic [CW-1:0]          watched, measured;

    // ------------------------------------------------------------
    // frame classification
    // ------------------------------------------------------------
    // length checks apply to both framings
    always_comb begin
        gfp       = ~i_hdlc_mode;
        rx_short  = i_rx_frame.valid && (i_rx_frame.length < MIN_FRAME_LEN);
        rx_over   = i_rx_frame.valid && (i_rx_frame.length > i_mtu);
        tx_short  = i_tx_frame.valid && (i_tx_frame.length < MIN_FRAME_LEN);
        tx_over   = i_tx_frame.valid && (i_tx_frame.length > i_mtu);
        rx_crc    = i_rx_frame.valid && i_rx_frame.crc_err && i_hdlc_mode;
        bad_type  = i_rx_frame.valid && gfp && !i_rx_frame.mgmt
                    && (i_rx_frame.ptype != i_expect_type);
        // a burst of header errors while already out of frame is not counted
        uncorr_if = gfp && i_hdr_uncorr && (delin_reg == GPSA_IN_FRAME);
    end

    // ------------------------------------------------------------
    // increments per counter
    // ------------------------------------------------------------
    always_comb begin
        inc = '0;
        inc[C_RX_OCT]     = i_rx_octets;                                   // RULE_01
        inc[C_RX_FRM]     = {7'h00, i_rx_frame.valid};
        inc[C_RX_ERR]     = {7'h00, rx_short | rx_over | rx_crc | bad_type
                             | (gfp & i_sblk_crc_err) | uncorr_if};
        inc[C_TX_OCT]     = i_tx_octets;
        inc[C_TX_FRM]     = {7'h00, i_tx_frame.valid};
        inc[C_TX_ERR]     = {7'h00, i_tx_drop};                            // RULE_07
        inc[C_RX_SHORT]   = {7'h00, rx_short};                             // RULE_02
        inc[C_RX_OVER]    = {7'h00, rx_over};                              // RULE_03
        inc[C_RX_CRC]     = {7'h00, rx_crc};                               // RULE_04
        inc[C_TX_CRC]     = {7'h00, i_tx_frame.valid & i_tx_frame.crc_err
                             & i_hdlc_mode};                               // RULE_05
        inc[C_TX_SHORT]   = {7'h00, tx_short};                             // RULE_06
        inc[C_TX_OVER]    = {7'h00, tx_over};                              // RULE_06
        // gfp frame counters exclude management frames; gfp octet counters do not
        inc[C_GFP_RX_FRM] = {7'h00, gfp & i_rx_frame.valid & ~i_rx_frame.mgmt}; // RULE_08
        inc[C_GFP_TX_FRM] = {7'h00, gfp & i_tx_frame.valid & ~i_tx_frame.mgmt}; // RULE_08
        inc[C_SBLK_CRC]   = {7'h00, gfp & i_sblk_crc_err};                 // RULE_09
        inc[C_GFP_RX_OCT] = gfp ? i_rx_octets : 8'h00;                     // RULE_08
        inc[C_GFP_TX_OCT] = gfp ? i_tx_octets : 8'h00;                     // RULE_08
        inc[C_HDR_CORR]   = {7'h00, gfp & i_hdr_corrected};                // RULE_10
        inc[C_HDR_UNCORR] = {7'h00, uncorr_if};                            // RULE_11
        inc[C_BAD_TYPE]   = {7'h00, bad_type};                             // RULE_12
        inc[C_LOF]        = {7'h00, uncorr_if};                            // RULE_13
        inc[C_RX_MGMT]    = {7'h00, gfp & i_rx_frame.valid & i_rx_frame.mgmt};
        inc[C_TX_MGMT]    = {7'h00, gfp & i_tx_frame.valid & i_tx_frame.mgmt};
    end

    // ------------------------------------------------------------
    // counter bank
    // ------------------------------------------------------------
    // clear restarts from this cycle's increment so no event is lost
    always_comb begin
        for (int k = 0; k < NCNT; k++) begin
            if (i_clear_stats) begin
                cnt_next[k] = {24'h000000, inc[k]};                        // RULE_18
            end else begin
                cnt_next[k] = cnt_reg[k] + {24'h000000, inc[k]};
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_reg <= '0;                                                 // RULE_18
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // ------------------------------------------------------------
    // delineation state and discard flag
    // ------------------------------------------------------------
    // uncorrectable header drops delineation; resync pulse regains it
    always_comb begin
        delin_next   = delin_reg;
        discard_next = bad_type;                                           // RULE_12
        unique case (delin_reg)
            GPSA_IN_FRAME: begin
                if (uncorr_if) begin
                    delin_next = GPSA_OUT_FRAME;                           // RULE_13
                end
            end
            GPSA_OUT_FRAME: begin
                if (i_gfp_sync) begin
                    delin_next = GPSA_IN_FRAME;
                end
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            delin_reg   <= GPSA_OUT_FRAME;
            discard_reg <= 1'b0;
        end else begin
            delin_reg   <= delin_next;
            discard_reg <= discard_next;
        end
    end

    // ------------------------------------------------------------
    // threshold alarm
    // ------------------------------------------------------------
    // a zero period samples every cycle; selector above the bank reads 0
    always_comb begin
        watched    = (i_alarm_sel < 5'(NCNT)) ? cnt_reg[i_alarm_sel] : CNT_RST;
        sample_now = (per_reg + 32'h0000_0001) >= i_sample_period;
        measured   = i_alarm_absolute ? watched : (watched - base_reg);    // RULE_14
        per_next   = sample_now ? PERIOD_RST : per_reg + 32'h0000_0001;
        base_next  = i_clear_stats ? CNT_RST : (sample_now ? watched : base_reg);
        val_next   = sample_now ? measured : val_reg;
        armed_next = armed_reg;
        event_next = 1'b0;
        if (sample_now) begin
            if (armed_reg && (measured > i_rise_thresh)) begin
                event_next = 1'b1;                                         // RULE_15
                armed_next = 1'b0;                                         // RULE_17
            end else if (!armed_reg && (measured < i_fall_thresh)) begin
                armed_next = 1'b1;                                         // RULE_16
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            per_reg   <= PERIOD_RST;
            base_reg  <= CNT_RST;
            val_reg   <= CNT_RST;
            armed_reg <= 1'b1;
            event_reg <= 1'b0;
        end else begin
            per_reg   <= per_next;
            base_reg  <= base_next;
            val_reg   <= val_next;
            armed_reg <= armed_next;
            event_reg <= event_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_counts      = cnt_reg;
    assign o_rx_discard  = discard_reg;
    assign o_in_frame    = (delin_reg == GPSA_IN_FRAME);
    assign o_alarm_value = val_reg;
    assign o_alarm_armed = armed_reg;
    assign o_alarm_event = event_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_rx_octets;
        @(posedge i_clock) disable iff (!i_resetn)
        !i_clear_stats |=> cnt_reg[C_RX_OCT] ==
            $past(cnt_reg[C_RX_OCT]) + {24'h000000, $past(i_rx_octets)};
    endproperty
    a_rx_octets: assert property (p_rx_octets)  // RULE_01
        else $error("rx octet count wrong");

    property p_rx_short;
        @(posedge i_clock) disable iff (!i_resetn)
        (!i_clear_stats && i_rx_frame.valid && i_rx_frame.length < MIN_FRAME_LEN)
            |=> cnt_reg[C_RX_SHORT] == $past(cnt_reg[C_RX_SHORT]) + 32'h0000_0001;
    endproperty
    a_rx_short: assert property (p_rx_short)  // RULE_02
        else $error("short frame not counted");

    property p_rx_over;
        @(posedge i_clock) disable iff (!i_resetn)
        (!i_clear_stats && i_rx_frame.valid && i_rx_frame.length <= i_mtu)
            |=> cnt_reg[C_RX_OVER] == $past(cnt_reg[C_RX_OVER]);
    endproperty
    a_rx_over: assert property (p_rx_over)  // RULE_03
        else $error("frame within mtu counted oversize");

    property p_crc_hdlc_only;
        @(posedge i_clock) disable iff (!i_resetn)
        (!i_clear_stats && !i_hdlc_mode) |=> $stable(cnt_reg[C_RX_CRC]);
    endproperty
    a_crc_hdlc_only: assert property (p_crc_hdlc_only)  // RULE_04
        else $error("crc counted outside hdlc");

    property p_lof_in_frame;
        @(posedge i_clock) disable iff (!i_resetn)
        (!i_clear_stats && delin_reg == GPSA_OUT_FRAME) |=> $stable(cnt_reg[C_LOF]);
    endproperty
    a_lof_in_frame: assert property (p_lof_in_frame)  // RULE_13
        else $error("loss of frame counted while out of frame");

    property p_bad_type;
        @(posedge i_clock) disable iff (!i_resetn)
        (bad_type && !i_clear_stats) |=> o_rx_discard
            && cnt_reg[C_BAD_TYPE] == $past(cnt_reg[C_BAD_TYPE]) + 32'h0000_0001;
    endproperty
    a_bad_type: assert property (p_bad_type)  // RULE_12
        else $error("bad type frame not discarded");

    property p_event_once;
        @(posedge i_clock) disable iff (!i_resetn)
        o_alarm_event |-> !o_alarm_armed && $past(o_alarm_armed)
            && o_alarm_value > $past(i_rise_thresh);
    endproperty
    a_event_once: assert property (p_event_once)  // RULE_17
        else $error("alarm event without arming");

    property p_rearm;
        @(posedge i_clock) disable iff (!i_resetn)
        (sample_now && !armed_reg && measured < i_fall_thresh) |=> o_alarm_armed;
    endproperty
    a_rearm: assert property (p_rearm)  // RULE_16
        else $error("alarm not rearmed");

    property p_clear;
        @(posedge i_clock) disable iff (!i_resetn)
        (i_clear_stats && !i_rx_frame.valid) |=> cnt_reg[C_RX_SHORT] == CNT_RST;
    endproperty
    a_clear: assert property (p_clear)  // RULE_18
        else $error("counter not cleared");

    // a drop strobe must land even though nothing else marks the frame
    property p_tx_drop;
        @(posedge i_clock) disable iff (!i_resetn)
        (i_tx_drop && !i_clear_stats)
            |=> cnt_reg[C_TX_ERR] == $past(cnt_reg[C_TX_ERR]) + 32'h0000_0001;
    endproperty
    a_tx_drop: assert property (p_tx_drop)  // RULE_07
        else $error("dropped unit not counted");

    // superblock errors only mean something under gfp framing
    property p_sblk_crc;
        @(posedge i_clock) disable iff (!i_resetn)
        (i_sblk_crc_err && !i_hdlc_mode && !i_clear_stats)
            |=> cnt_reg[C_SBLK_CRC] == $past(cnt_reg[C_SBLK_CRC]) + 32'h0000_0001;
    endproperty
    a_sblk_crc: assert property (p_sblk_crc)  // RULE_09
        else $error("superblock crc error not counted");

    c_event: cover property (@(posedge i_clock) disable iff (!i_resetn) o_alarm_event);
    c_rearm: cover property (@(posedge i_clock) disable iff (!i_resetn)
        !o_alarm_armed ##1 o_alarm_armed);
    c_lof:   cover property (@(posedge i_clock) disable iff (!i_resetn)
        o_in_frame ##1 !o_in_frame);
    c_discard: cover property (@(posedge i_clock) disable iff (!i_resetn) o_rx_discard);
endmodule

// file: sim/gpsa_dpm.sv
// framing datapath stand-in: turns bench calls into one-cycle event strobes
// assumes the stats block samples every input on the rising clock edge
`timescale 1ns/100ps
module gpsa_dpm
    import gpsa_pkg::*;
(
    // clock
    input  wire logic      i_clock,
    // event strobes towards the stats block
    output logic [7:0]     o_rx_octets,
    output gpsa_rx_frame_t o_rx_frame,
    output logic [7:0]     o_tx_octets,
    output gpsa_tx_frame_t o_tx_frame,
    output logic [4:0]     o_events     // sblk, corr, uncorr, sync, drop
);
    // ----------
    // idle state
    // ----------
    // octets idle at zero, since zero is a real count for this port
    initial begin
        o_rx_octets = 8'h00;
        o_rx_frame  = '0;
        o_tx_octets = 8'h00;
        o_tx_frame  = '0;
        o_events    = 5'h00;
    end
    // ----------
    // strobe tasks
    // ----------
    // one received frame end, its octets on the same cycle
    task automatic rx(input logic [15:0] len, input logic crc, input logic mgmt,
                      input logic [3:0] ptype, input logic [7:0] oct);
        @(negedge i_clock);
        o_rx_frame  <= '{1'b1, len, crc, mgmt, ptype};
        o_rx_octets <= oct;
        @(negedge i_clock);
        o_rx_frame  <= '0;     // strobe lasts exactly one cycle
        o_rx_octets <= 8'h00;
    endtask
    // one transmitted frame end
    task automatic tx(input logic [15:0] len, input logic crc, input logic mgmt,
                      input logic [7:0] oct);
        @(negedge i_clock);
        o_tx_frame  <= '{1'b1, len, crc, mgmt};
        o_tx_octets <= oct;
        @(negedge i_clock);
        o_tx_frame  <= '0;
        o_tx_octets <= 8'h00;
    endtask
    // single-bit events; a gap cycle follows so strobes never merge
    task automatic pulse(input logic [4:0] ev);
        @(negedge i_clock);
        o_events <= ev;
        @(negedge i_clock);
        o_events <= 5'h00;
    endtask
endmodule

// file: sim/tb_gpsa_stats.sv
// bench for the port statistics block: scenario tasks set config, model strobes events
// assumes gpsa_pkg and the datapath model are compiled first
`timescale 1ns/100ps
module tb_gpsa_stats
    import gpsa_pkg::*;
();
    // ----------
    // bench signals
    // ----------
    localparam logic [4:0] E_SBLK = 5'h10, E_CORR = 5'h08, E_UNC = 5'h04;
    localparam logic [4:0] E_SYNC = 5'h02, E_DROP = 5'h01;
    logic           clock;        // 100 MHz
    logic           resetn;       // async, low active
    logic           hdlc_mode;    // framing select
    logic [15:0]    mtu;
    logic [3:0]     exp_type;
    logic           clear_stats;
    logic [4:0]     alarm_sel;
    logic           alarm_abs;
    logic [CW-1:0]  period;
    logic [CW-1:0]  rise;
    logic [CW-1:0]  fall;
    logic [7:0]     rx_oct;
    gpsa_rx_frame_t rx_frame;
    logic [7:0]     tx_oct;
    gpsa_tx_frame_t tx_frame;
    logic [4:0]     ev;           // sblk, corr, uncorr, sync, drop
    logic           discard;
    logic           in_frame;
    gpsa_cnt_arr_t  cnt;
    logic [CW-1:0]  a_value;
    logic           a_armed;
    logic           a_event;
    int             num_errors = 0;
    int             n_checks = 0;
    int             ev_cnt = 0;   // alarm pulses seen
    // ----------
    // instances
    // ----------
    gpsa_dpm i_gpsa_dpm (.i_clock(clock), .o_rx_octets(rx_oct), .o_rx_frame(rx_frame),
        .o_tx_octets(tx_oct), .o_tx_frame(tx_frame), .o_events(ev));
    gpsa_stats i_gpsa_stats (.i_clock(clock), .i_resetn(resetn), .i_hdlc_mode(hdlc_mode),
        .i_mtu(mtu), .i_expect_type(exp_type), .i_clear_stats(clear_stats),
        .i_rx_octets(rx_oct), .i_rx_frame(rx_frame), .i_sblk_crc_err(ev[4]),
        .i_hdr_corrected(ev[3]), .i_hdr_uncorr(ev[2]), .i_gfp_sync(ev[1]),
        .i_tx_octets(tx_oct), .i_tx_frame(tx_frame), .i_tx_drop(ev[0]),
        .i_alarm_sel(alarm_sel), .i_alarm_absolute(alarm_abs), .i_sample_period(period),
        .i_rise_thresh(rise), .i_fall_thresh(fall), .o_rx_discard(discard),
        .o_in_frame(in_frame), .o_counts(cnt), .o_alarm_value(a_value),
        .o_alarm_armed(a_armed), .o_alarm_event(a_event));
    // ----------
    // helpers
    // ----------
    // alarm pulses are one cycle wide, so one sample per edge counts each once
    always @(posedge clock) begin
        if (a_event === 1'b1) begin
            ev_cnt++;
        end
    end
    task automatic chk(input logic [CW-1:0] got, input logic [CW-1:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask
    // clear pulse; framing mode changes in the same cycle
    task automatic clear_all(input logic hdlc);
        @(negedge clock);
        clear_stats <= 1'b1;
        hdlc_mode   <= hdlc;
        @(negedge clock);
        clear_stats <= 1'b0;
    endtask
    task automatic corr(input int n);
        repeat (n) i_gpsa_dpm.pulse(E_CORR);
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_reset();
        for (int k = 0; k < NCNT; k++) begin
            chk(cnt[k], CNT_RST, "count after reset");
        end
        chk(CW'(in_frame), 32'h0, "in frame after reset");
        chk(CW'(a_armed), 32'h1, "armed after reset");
    endtask
    // hdlc receive: length boundaries 4/5 and mtu/mtu+1, payload crc
    task automatic t_hdlc_rx();
        clear_all(1'b1);
        i_gpsa_dpm.rx(16'h0004, 1'b0, 1'b0, 4'h3, 8'h04);
        i_gpsa_dpm.rx(16'h0005, 1'b1, 1'b0, 4'h3, 8'h05);
        i_gpsa_dpm.rx(16'h0064, 1'b0, 1'b0, 4'h3, 8'h64);
        i_gpsa_dpm.rx(16'h0065, 1'b0, 1'b0, 4'h3, 8'h65);
        chk(cnt[C_RX_SHORT], 32'h1, "rx short");
        chk(cnt[C_RX_OVER], 32'h1, "rx oversize");
        chk(cnt[C_RX_CRC], 32'h1, "rx crc");
        chk(cnt[C_RX_OCT], 32'hd2, "rx octets");
        chk(cnt[C_RX_FRM], 32'h4, "rx frames");
        chk(cnt[C_RX_ERR], 32'h3, "rx errors");
        chk(cnt[C_GFP_RX_FRM], 32'h0, "gfp frames in hdlc");
    endtask
    task automatic t_hdlc_tx();
        clear_all(1'b1);
        i_gpsa_dpm.tx(16'h0004, 1'b0, 1'b0, 8'h04);
        i_gpsa_dpm.tx(16'h0005, 1'b1, 1'b0, 8'h05);
        i_gpsa_dpm.tx(16'h0065, 1'b0, 1'b0, 8'h65);
        chk(cnt[C_TX_SHORT], 32'h1, "tx short");
        chk(cnt[C_TX_OVER], 32'h1, "tx oversize");
        chk(cnt[C_TX_CRC], 32'h1, "tx crc");
        chk(cnt[C_TX_OCT], 32'h6e, "tx octets");
        chk(cnt[C_TX_FRM], 32'h3, "tx frames");
    endtask
    // gfp: frames, octets, mgmt frames, superblock, header fix, wrong type
    task automatic t_gfp();
        clear_all(1'b0);
        i_gpsa_dpm.rx(16'h000a, 1'b0, 1'b0, 4'h3, 8'h0a);
        i_gpsa_dpm.rx(16'h000a, 1'b0, 1'b0, 4'h3, 8'h0a);
        i_gpsa_dpm.rx(16'h000a, 1'b0, 1'b1, 4'h5, 8'h00);
        i_gpsa_dpm.tx(16'h0014, 1'b0, 1'b0, 8'h14);
        i_gpsa_dpm.tx(16'h0014, 1'b0, 1'b1, 8'h00);
        i_gpsa_dpm.pulse(E_SBLK | E_CORR);
        chk(cnt[C_GFP_RX_FRM], 32'h2, "gfp rx frames");
        chk(cnt[C_GFP_RX_OCT], 32'h14, "gfp rx octets");
        chk(cnt[C_GFP_TX_FRM], 32'h1, "gfp tx frames");
        chk(cnt[C_GFP_TX_OCT], 32'h14, "gfp tx octets");
        chk(cnt[C_RX_MGMT] + cnt[C_TX_MGMT], 32'h2, "mgmt frames");
        chk(cnt[C_SBLK_CRC], 32'h1, "superblock crc");
        chk(cnt[C_HDR_CORR], 32'h1, "header fixed");
        i_gpsa_dpm.rx(16'h000a, 1'b0, 1'b0, 4'h5, 8'h00);
        chk(CW'(discard), 32'h1, "discard strobe");
        idle(1);
        chk(CW'(discard), 32'h0, "discard one cycle");
        chk(cnt[C_BAD_TYPE], 32'h1, "bad type");
        i_gpsa_dpm.rx(16'h000a, 1'b1, 1'b0, 4'h3, 8'h00);
        chk(cnt[C_RX_CRC], 32'h0, "crc in gfp");
    endtask
    // uncorrectable headers count only while in frame
    task automatic t_lof();
        clear_all(1'b0);
        i_gpsa_dpm.pulse(E_UNC);
        chk(cnt[C_HDR_UNCORR], 32'h0, "uncorr out of frame");
        i_gpsa_dpm.pulse(E_SYNC);
        chk(CW'(in_frame), 32'h1, "sync");
        i_gpsa_dpm.pulse(E_UNC);
        chk(cnt[C_HDR_UNCORR], 32'h1, "uncorr in frame");
        chk(cnt[C_LOF], 32'h1, "loss of frame");
        chk(CW'(in_frame), 32'h0, "out of frame");
    endtask
    // clear and a drop on the same edge: the drop survives
    task automatic t_clear_drop();
        fork
            clear_all(1'b0);
            i_gpsa_dpm.pulse(E_DROP);
        join
        chk(cnt[C_TX_ERR], 32'h1, "drop with clear");
        chk(cnt[C_HDR_UNCORR], 32'h0, "cleared");
    endtask
    task automatic t_alarm_abs();
        clear_all(1'b0);
        idle(12);
        chk(CW'(a_armed), 32'h1, "armed at zero");
        ev_cnt = 0;
        corr(8);
        idle(12);
        chk(CW'(ev_cnt), 32'h1, "first crossing");
        corr(2);
        idle(12);
        chk(CW'(ev_cnt), 32'h1, "no repeat event");
        chk(a_value, 32'h0a, "absolute total");
        clear_all(1'b0);
        idle(12);
        chk(CW'(a_armed), 32'h1, "rearmed");
        corr(8);
        idle(12);
        chk(CW'(ev_cnt), 32'h2, "event after rearm");
    endtask
    // per-period delta; bursts of six strobes always put at least three in one period
    task automatic t_alarm_rel();
        @(negedge clock);
        alarm_abs <= 1'b0;
        period    <= 32'h8;
        rise      <= 32'h2;
        fall      <= 32'h1;
        idle(20);
        chk(a_value, 32'h0, "relative delta");
        ev_cnt = 0;
        corr(6);
        idle(20);
        chk(CW'(ev_cnt), 32'h1, "burst event");
        chk(CW'(a_armed), 32'h1, "quiet rearms");
        corr(6);
        idle(20);
        chk(CW'(ev_cnt), 32'h2, "second burst");
    endtask
    // ----------
    // clock, watchdog and main sequence
    // ----------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        #50000;
        num_errors++;
        finish_test();
    end
    initial begin
        resetn      = 1'b0;
        hdlc_mode   = 1'b1;
        mtu         = 16'h0064;
        exp_type    = 4'h3;
        clear_stats = 1'b0;
        alarm_sel   = 5'h11;      // header corrected counter
        alarm_abs   = 1'b1;
        period      = 32'h4;
        rise        = 32'h5;
        fall        = 32'h2;
        idle(2);
        resetn <= 1'b1;
        t_reset();
        t_hdlc_rx();
        t_hdlc_tx();
        t_gfp();
        t_lof();
        t_clear_drop();
        t_alarm_abs();
        t_alarm_rel();
        finish_test();
    end
endmodule
